// >>> logic/status_event_defs.svh
`ifndef STATUS_EVENT_DEFS_SVH
`define STATUS_EVENT_DEFS_SVH

// Standard event latch fields
`define STD_OPC_BIT          0
`define STD_REQ_CTRL_BIT     1
`define STD_USED_MASK        8'hfd

// Source event group fields
`define SRC_SAMPLING_BIT     7
`define SRC_READY_BIT        5
`define SRC_STORE_BIT        2
`define SRC_TURN_BIT         1
`define SRC_SWEEP_BIT        0
`define SRC_USED_MASK        8'ha7

// Measure event group fields
`define MEAS_SAMPLING_BIT    7
`define MEAS_DONE_BIT        6
`define MEAS_OVERRANGE_BIT   5
`define MEAS_HI_LIMIT_BIT    3
`define MEAS_LO_LIMIT_BIT    2
`define MEAS_CMP_HI_BIT      1
`define MEAS_CMP_LO_BIT      0
`define MEAS_USED_MASK       8'hef

// Reset values
`define EVENT_RESET          8'h00
`define ENABLE_RESET         8'h00

// Error codes, two's complement
`define ERR_QUEUE_OVERFLOW   16'hfea2
`define ERR_NONE             16'h0000

`endif

// >>> logic/status_event_pkg.sv
package status_event_pkg;

    typedef enum logic [2:0] {
        SEL_STD_LATCH   = 3'b000,
        SEL_STD_ENABLE  = 3'b001,
        SEL_SRC_COND    = 3'b010,
        SEL_SRC_EVENT   = 3'b011,
        SEL_SRC_ENABLE  = 3'b100,
        SEL_MEAS_COND   = 3'b101,
        SEL_MEAS_EVENT  = 3'b110,
        SEL_MEAS_ENABLE = 3'b111
    } reg_sel_t;

    typedef enum logic {
        OPC_IDLE = 1'b0,
        OPC_WAIT = 1'b1
    } opc_state_t;

endpackage : status_event_pkg

// >>> logic/instrument_status_event_registers.sv
// Summary of operation
// - Event summary bit set when any standard latch bit and its enable are 1.
// - Standard latch cleared by its read, by clear-status, and at power-up.
// - Bit 0 set once operations pending at the command finish; bit 1 reads 0.
// - Standard bits with enable 0 never reach the summary; mask written and read back.
// - Early trigger sets bit 7 in both source and measure event registers.
// - Source condition bit 5 follows sweep readiness; event bit 5 latches on rise.
// - Source event bits 2, 1, 0 for store, sweep turn, sweep end; 6,4,3 read 0.
// - Source event bit reaches source summary only when its enable bit is 1.
// - Condition reads return live state and leave the register unchanged.
// - Source event register cleared by its read, clear-status, and power-up.
// - Measure event bit 6 set on each completed measurement.
// - Measure condition bit 5 follows overrange; event bit 5 latches on rise.
// - Measure bits 3 and 2 follow high and low limiter; events latch on rise.
// - Measure bits 1 and 0 follow compare results; events on rise; bit 4 reads 0.
// - Measure event bit reaches measure summary only when its enable bit is 1.
// - Measure event register cleared by its read, clear-status, and power-up.
// - Query responses are stored record by record and returned first in, first out.
// - Output queue flushed on new message, deadlock, device clear, power-up; not clear-status.
// - Message available bit is high while the output queue holds a record.
// - Error queue keeps number and message, returned oldest first.
// - On error queue overflow the newest entry becomes error minus 350.
// - Error queue empties by reading, by clear-status, and at power-up.
// - Measure summary is status bit 0, set when measure event and enable both 1.
`timescale 1ns/10ps
`include "status_event_defs.svh"

module instrument_status_event_registers #(
    parameter int OQ_WIDTH     = 8,
    parameter int OQ_DEPTH     = 16,
    parameter int EQ_MSG_WIDTH = 8,
    parameter int EQ_DEPTH     = 8,
    parameter logic [EQ_MSG_WIDTH-1:0] OVERFLOW_MSG_ID = 8'h01
) (
    // Clock and reset
    input  wire logic                            clock_in,
    input  wire logic                            reset_in,
    // Register command port
    input  wire logic                            read_req_in,
    input  wire status_event_pkg::reg_sel_t      read_sel_in,
    input  wire logic                            write_req_in,
    input  wire status_event_pkg::reg_sel_t      write_sel_in,
    input  wire logic [7:0]                      write_data_in,
    input  wire logic                            clear_status_in,
    output logic      [7:0]                      read_data_out,
    output logic                                 read_valid_out,
    // Operation complete tracking
    input  wire logic                            opc_cmd_in,
    input  wire logic                            ops_pending_in,
    input  wire logic [7:2]                      std_event_in,
    // Source and measure event pulses
    input  wire logic                            sampling_error_in,
    input  wire logic                            store_done_in,
    input  wire logic                            sweep_turn_in,
    input  wire logic                            sweep_end_in,
    input  wire logic                            measurement_done_in,
    // Condition pins, asynchronous
    input  wire logic                            sweep_ready_in,
    input  wire logic                            overrange_in,
    input  wire logic                            high_limiter_in,
    input  wire logic                            low_limiter_in,
    input  wire logic                            compare_high_in,
    input  wire logic                            compare_low_in,
    // Output queue
    input  wire logic                            oq_push_in,
    input  wire logic [OQ_WIDTH-1:0]             oq_data_in,
    input  wire logic                            oq_pop_in,
    input  wire logic                            new_message_in,
    input  wire logic                            deadlock_in,
    input  wire logic                            device_clear_in,
    output logic      [OQ_WIDTH-1:0]             oq_data_out,
    output logic                                 oq_valid_out,
    // Error queue
    input  wire logic                            eq_push_in,
    input  wire logic [15:0]                     eq_number_in,
    input  wire logic [EQ_MSG_WIDTH-1:0]         eq_msg_in,
    input  wire logic                            eq_pop_in,
    output logic      [15:0]                     eq_number_out,
    output logic      [EQ_MSG_WIDTH-1:0]         eq_msg_out,
    output logic                                 eq_valid_out,
    // Status byte summary bits
    output logic                                 event_summary_bit_out,
    output logic                                 message_available_bit_out,
    output logic                                 error_available_out,
    output logic                                 source_summary_bit_out,
    output logic                                 measure_summary_bit_out
);

    localparam int OQ_AW = $clog2(OQ_DEPTH);
    localparam int EQ_AW = $clog2(EQ_DEPTH);
    localparam logic [OQ_AW:0] OQ_FULL = (OQ_AW+1)'(OQ_DEPTH);
    localparam logic [EQ_AW:0] EQ_FULL = (EQ_AW+1)'(EQ_DEPTH);

    function automatic logic [7:0] latch_next(input logic [7:0] cur, input logic clr,
                                              input logic [7:0] set, input logic [7:0] used);
        latch_next = ((clr ? `EVENT_RESET : cur) | set) & used;
    endfunction : latch_next

    logic [7:0]                  std_latch;
    logic [7:0]                  std_enable;
    logic [7:0]                  src_event;
    logic [7:0]                  src_enable;
    logic [7:0]                  meas_event;
    logic [7:0]                  meas_enable;
    logic [7:0]                  src_cond;
    logic [7:0]                  meas_cond;
    logic [7:0]                  std_set;
    logic [7:0]                  src_set;
    logic [7:0]                  meas_set;
    logic                        opc_set;
    status_event_pkg::opc_state_t opc_state;
    logic [5:0]                  cond_sync1;
    logic [5:0]                  cond_sync2;
    logic [5:0]                  cond_prev;
    logic [5:0]                  cond_rise;
    logic                        std_clear;
    logic                        src_clear;
    logic                        meas_clear;

    // Two-stage synchronisers for condition pins
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cond_sync1 <= 6'h00;
            cond_sync2 <= 6'h00;
            cond_prev  <= 6'h00;
        end else begin
            cond_sync1 <= {sweep_ready_in, overrange_in, high_limiter_in,
                           low_limiter_in, compare_high_in, compare_low_in};
            cond_sync2 <= cond_sync1;
            cond_prev  <= cond_sync2;
        end
    end

    assign cond_rise = cond_sync2 & ~cond_prev;

    always_comb begin
        src_cond                     = 8'h00;
        src_cond[`SRC_READY_BIT]     = cond_sync2[5];
        meas_cond                    = 8'h00;
        meas_cond[`MEAS_OVERRANGE_BIT] = cond_sync2[4];
        meas_cond[`MEAS_HI_LIMIT_BIT]  = cond_sync2[3];
        meas_cond[`MEAS_LO_LIMIT_BIT]  = cond_sync2[2];
        meas_cond[`MEAS_CMP_HI_BIT]    = cond_sync2[1];
        meas_cond[`MEAS_CMP_LO_BIT]    = cond_sync2[0];
    end

    always_comb begin
        std_set                       = {std_event_in, 2'b00};
        std_set[`STD_OPC_BIT]         = opc_set;
        src_set                       = 8'h00;
        src_set[`SRC_SAMPLING_BIT]    = sampling_error_in;
        src_set[`SRC_READY_BIT]       = cond_rise[5];
        src_set[`SRC_STORE_BIT]       = store_done_in;
        src_set[`SRC_TURN_BIT]        = sweep_turn_in;
        src_set[`SRC_SWEEP_BIT]       = sweep_end_in;
        meas_set                      = 8'h00;
        meas_set[`MEAS_SAMPLING_BIT]  = sampling_error_in;
        meas_set[`MEAS_DONE_BIT]      = measurement_done_in;
        meas_set[`MEAS_OVERRANGE_BIT] = cond_rise[4];
        meas_set[`MEAS_HI_LIMIT_BIT]  = cond_rise[3];
        meas_set[`MEAS_LO_LIMIT_BIT]  = cond_rise[2];
        meas_set[`MEAS_CMP_HI_BIT]    = cond_rise[1];
        meas_set[`MEAS_CMP_LO_BIT]    = cond_rise[0];
    end

    assign std_clear  = clear_status_in
                     || (read_req_in && read_sel_in == status_event_pkg::SEL_STD_LATCH);
    assign src_clear  = clear_status_in
                     || (read_req_in && read_sel_in == status_event_pkg::SEL_SRC_EVENT);
    assign meas_clear = clear_status_in
                     || (read_req_in && read_sel_in == status_event_pkg::SEL_MEAS_EVENT);

    // Operation complete waits for pending work to drain
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            opc_state <= status_event_pkg::OPC_IDLE;
        end else begin
            case (opc_state)
                status_event_pkg::OPC_IDLE: begin
                    if (opc_cmd_in && ops_pending_in) begin
                        opc_state <= status_event_pkg::OPC_WAIT;
                    end
                end
                status_event_pkg::OPC_WAIT: begin
                    if (!ops_pending_in) begin
                        opc_state <= status_event_pkg::OPC_IDLE;
                    end
                end
                default: opc_state <= status_event_pkg::OPC_IDLE;
            endcase
        end
    end

    assign opc_set = (opc_state == status_event_pkg::OPC_IDLE && opc_cmd_in && !ops_pending_in)
                  || (opc_state == status_event_pkg::OPC_WAIT && !ops_pending_in);

    // Event latches: a set in the clearing cycle survives
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            std_latch  <= `EVENT_RESET;
            src_event  <= `EVENT_RESET;
            meas_event <= `EVENT_RESET;
        end else begin
            std_latch  <= latch_next(std_latch, std_clear, std_set, `STD_USED_MASK);
            src_event  <= latch_next(src_event, src_clear, src_set, `SRC_USED_MASK);
            meas_event <= latch_next(meas_event, meas_clear, meas_set, `MEAS_USED_MASK);
        end
    end

    // Enable masks
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            std_enable  <= `ENABLE_RESET;
            src_enable  <= `ENABLE_RESET;
            meas_enable <= `ENABLE_RESET;
        end else if (write_req_in) begin
            case (write_sel_in)
                status_event_pkg::SEL_STD_ENABLE:  std_enable  <= write_data_in;
                status_event_pkg::SEL_SRC_ENABLE:  src_enable  <= write_data_in;
                status_event_pkg::SEL_MEAS_ENABLE: meas_enable <= write_data_in;
                default: ;
            endcase
        end
    end

    // Read port
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            read_data_out  <= 8'h00;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= read_req_in;
            if (read_req_in) begin
                case (read_sel_in)
                    status_event_pkg::SEL_STD_LATCH:   read_data_out <= std_latch;
                    status_event_pkg::SEL_STD_ENABLE:  read_data_out <= std_enable;
                    status_event_pkg::SEL_SRC_COND:    read_data_out <= src_cond;
                    status_event_pkg::SEL_SRC_EVENT:   read_data_out <= src_event;
                    status_event_pkg::SEL_SRC_ENABLE:  read_data_out <= src_enable;
                    status_event_pkg::SEL_MEAS_COND:   read_data_out <= meas_cond;
                    status_event_pkg::SEL_MEAS_EVENT:  read_data_out <= meas_event;
                    status_event_pkg::SEL_MEAS_ENABLE: read_data_out <= meas_enable;
                    default:                           read_data_out <= 8'h00;
                endcase
            end
        end
    end

    // Summary bits of the status byte
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            event_summary_bit_out   <= 1'b0;
            source_summary_bit_out  <= 1'b0;
            measure_summary_bit_out <= 1'b0;
        end else begin
            event_summary_bit_out   <= |(std_latch & std_enable);
            source_summary_bit_out  <= |(src_event & src_enable);
            measure_summary_bit_out <= |(meas_event & meas_enable);
        end
    end

    // Output queue
    logic [OQ_WIDTH-1:0] oq_mem [OQ_DEPTH];
    logic [OQ_AW-1:0]    oq_rd;
    logic [OQ_AW-1:0]    oq_wr;
    logic [OQ_AW:0]      oq_count;
    logic                oq_flush;
    logic                oq_do_push;
    logic                oq_do_pop;
    logic [OQ_AW-1:0]    next_oq_rd;
    logic [OQ_AW-1:0]    next_oq_wr;
    logic [OQ_AW:0]      next_oq_count;

    assign oq_flush   = new_message_in || deadlock_in || device_clear_in;
    assign oq_do_pop  = oq_pop_in && !oq_flush && oq_count != '0;
    assign oq_do_push = oq_push_in && (oq_flush || oq_count != OQ_FULL);

    always_comb begin
        next_oq_rd    = oq_flush ? '0 : oq_rd;
        next_oq_wr    = oq_flush ? '0 : oq_wr;
        next_oq_count = oq_flush ? '0 : oq_count;
        if (oq_do_pop) begin
            next_oq_rd = oq_rd + 1'b1;
        end
        if (oq_do_push) begin
            next_oq_wr = next_oq_wr + 1'b1;
        end
        next_oq_count = next_oq_count + (OQ_AW+1)'(oq_do_push) - (OQ_AW+1)'(oq_do_pop);
    end

    always_ff @(posedge clock_in) begin
        if (oq_do_push) begin
            oq_mem[oq_flush ? '0 : oq_wr] <= oq_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            oq_rd                     <= '0;
            oq_wr                     <= '0;
            oq_count                  <= '0;
            oq_data_out               <= '0;
            oq_valid_out              <= 1'b0;
            message_available_bit_out <= 1'b0;
        end else begin
            oq_rd                     <= next_oq_rd;
            oq_wr                     <= next_oq_wr;
            oq_count                  <= next_oq_count;
            oq_valid_out              <= oq_do_pop;
            message_available_bit_out <= next_oq_count != '0;
            if (oq_do_pop) begin
                oq_data_out <= oq_mem[oq_rd];
            end
        end
    end

    // Error queue
    logic [15+EQ_MSG_WIDTH:0] eq_mem [EQ_DEPTH];
    logic [EQ_AW-1:0]         eq_rd;
    logic [EQ_AW-1:0]         eq_wr;
    logic [EQ_AW:0]           eq_count;
    logic                     eq_do_push;
    logic                     eq_do_pop;
    logic                     eq_overflow;
    logic [EQ_AW:0]           next_eq_count;

    assign eq_do_pop   = eq_pop_in && !clear_status_in && eq_count != '0;
    assign eq_do_push  = eq_push_in && (clear_status_in || eq_count != EQ_FULL || eq_do_pop);
    assign eq_overflow = eq_push_in && !eq_do_push;
    assign next_eq_count = (clear_status_in ? '0 : eq_count)
                         + (EQ_AW+1)'(eq_do_push) - (EQ_AW+1)'(eq_do_pop);

    always_ff @(posedge clock_in) begin
        if (eq_do_push) begin
            eq_mem[clear_status_in ? '0 : eq_wr] <= {eq_number_in, eq_msg_in};
        end else if (eq_overflow) begin
            eq_mem[eq_wr - 1'b1] <= {`ERR_QUEUE_OVERFLOW, OVERFLOW_MSG_ID};
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            eq_rd               <= '0;
            eq_wr               <= '0;
            eq_count            <= '0;
            eq_number_out       <= `ERR_NONE;
            eq_msg_out          <= '0;
            eq_valid_out        <= 1'b0;
            error_available_out <= 1'b0;
        end else begin
            eq_rd               <= clear_status_in ? '0 : eq_rd + EQ_AW'(eq_do_pop);
            eq_wr               <= (clear_status_in ? '0 : eq_wr) + EQ_AW'(eq_do_push);
            eq_count            <= next_eq_count;
            eq_valid_out        <= eq_pop_in;
            error_available_out <= next_eq_count != '0;
            if (eq_pop_in) begin
                {eq_number_out, eq_msg_out} <= eq_do_pop ? eq_mem[eq_rd]
                                                         : {`ERR_NONE, EQ_MSG_WIDTH'(0)};
            end
        end
    end

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    sequence opc_waiting_s;
        opc_state == status_event_pkg::OPC_WAIT && !ops_pending_in;
    endsequence

    sequence read_cond_s;
        read_req_in && read_sel_in == status_event_pkg::SEL_SRC_COND;
    endsequence

    a_esb_summary: assert property ((std_latch & std_enable) != 8'h00 |=> event_summary_bit_out)
        else $error("event summary not raised");
    a_esb_masked: assert property ((std_latch & std_enable) == 8'h00 |=> !event_summary_bit_out)
        else $error("masked standard bit reached summary");
    a_std_clear_read: assert property (std_clear && std_set == 8'h00 |=> std_latch == 8'h00)
        else $error("standard latch not cleared");
    a_opc_complete: assert property (opc_waiting_s |=> std_latch[`STD_OPC_BIT] && std_latch[1] == 1'b0)
        else $error("operation complete not latched");
    a_sampling_both: assert property (sampling_error_in |=> src_event[7] && meas_event[7])
        else $error("sampling error not in both registers");
    a_ready_edge: assert property ($rose(sweep_ready_in) && !src_clear ##2 !src_clear |=> src_event[`SRC_READY_BIT])
        else $error("ready edge not latched");
    a_src_unused: assert property ((src_event & ~`SRC_USED_MASK) == 8'h00 && !meas_event[4])
        else $error("unused event bit set");
    a_ssb_gate: assert property (source_summary_bit_out == |($past(src_event) & $past(src_enable)))
        else $error("source summary wrong");
    a_cond_read: assert property (read_cond_s |=> read_valid_out && read_data_out == $past(src_cond))
        else $error("condition read wrong");
    a_src_clear: assert property (src_clear && src_set == 8'h00 |=> src_event == 8'h00)
        else $error("source event not cleared");
    a_meas_done: assert property (measurement_done_in |=> meas_event[`MEAS_DONE_BIT])
        else $error("measurement done not latched");
    a_meas_edges: assert property (meas_set[5:0] != 6'h00 |=> (meas_event[5:0] & $past(meas_set[5:0])) == $past(meas_set[5:0]))
        else $error("measure edge not latched");
    a_meas_clear: assert property (meas_clear && meas_set == 8'h00 |=> meas_event == 8'h00)
        else $error("measure event not cleared");
    a_msb_gate: assert property ((meas_event & meas_enable) != 8'h00 |=> measure_summary_bit_out)
        else $error("measure summary not raised");
    a_event_sticky: assert property (!src_clear |=> (src_event & $past(src_event)) == $past(src_event))
        else $error("source event bit lost");
    a_oq_flush: assert property (oq_flush && !oq_push_in |=> oq_count == '0 && !message_available_bit_out)
        else $error("output queue not flushed");
    a_oq_mav: assert property (message_available_bit_out == (oq_count != '0))
        else $error("message available wrong");
    a_eq_overflow: assert property (eq_overflow |=> eq_count == EQ_FULL && eq_mem[eq_wr - 1'b1][15+EQ_MSG_WIDTH:EQ_MSG_WIDTH] == `ERR_QUEUE_OVERFLOW)
        else $error("overflow entry wrong");
    a_eq_cls: assert property (clear_status_in && !eq_push_in |=> eq_count == '0 && !error_available_out)
        else $error("error queue not emptied");

endmodule : instrument_status_event_registers

// >>> test/cmd_ctl_model.sv
`timescale 1ns/10ps
module cmd_ctl_model (
    // Clock and answer
    input  wire logic                  clock_in,
    input  wire logic                  read_valid_in,
    input  wire logic [7:0]            read_data_in,
    // Command drive
    output logic                       read_req_out,
    output logic                       write_req_out,
    output logic                       clear_status_out,
    output status_event_pkg::reg_sel_t sel_out,
    output logic [7:0]                 write_data_out
);
    initial begin
        {read_req_out, write_req_out, clear_status_out} = 3'h0;
        sel_out = status_event_pkg::SEL_STD_LATCH;
        write_data_out = 8'h00;
    end
    // One-cycle request; answer taken when it is dropped
    task automatic issue(input logic [2:0] kind, input status_event_pkg::reg_sel_t s,
                         input logic [7:0] v, output logic [8:0] d);
        @(negedge clock_in);
        {read_req_out, write_req_out, clear_status_out} = kind;
        sel_out = s;
        write_data_out = v;
        @(negedge clock_in);
        {read_req_out, write_req_out, clear_status_out} = 3'h0;
        d = {read_valid_in, read_data_in};
    endtask : issue
endmodule : cmd_ctl_model

// >>> test/instrument_status_event_registers_tb_top.sv
`timescale 1ns/10ps
module instrument_status_event_registers_tb_top;
    logic                       clock_in = 1'b0;
    logic                       reset_in = 1'b1;
    logic [19:0]                p = 20'h00000;
    logic [7:0]                 od = 8'h00;
    logic [15:0]                en = 16'h0000;
    int                         miscompares = 0;
    int                         n_tests = 0;
    logic                       rq, wq, cs, rv, ov, ev, s_evt, s_msg, s_err, s_src, s_meas;
    logic [7:0]                 wd, rdat, oq, emo;
    logic [15:0]                eno;
    logic [8:0]                 junk;
    status_event_pkg::reg_sel_t sel;
    always #12.5 clock_in = ~clock_in;
    cmd_ctl_model ctl (.clock_in(clock_in), .read_valid_in(rv), .read_data_in(rdat),
        .read_req_out(rq), .write_req_out(wq), .clear_status_out(cs), .sel_out(sel),
        .write_data_out(wd));
    instrument_status_event_registers #(.EQ_DEPTH(2)) dut (
        .clock_in(clock_in), .reset_in(reset_in), .read_req_in(rq), .read_sel_in(sel),
        .write_req_in(wq), .write_sel_in(sel), .write_data_in(wd), .clear_status_in(cs),
        .read_data_out(rdat), .read_valid_out(rv), .opc_cmd_in(p[0]), .ops_pending_in(p[1]),
        .std_event_in(6'h00), .sampling_error_in(p[2]), .store_done_in(p[3]),
        .sweep_turn_in(p[4]), .sweep_end_in(p[5]), .measurement_done_in(p[6]),
        .sweep_ready_in(p[7]), .overrange_in(p[8]), .high_limiter_in(p[16]),
        .low_limiter_in(p[17]), .compare_high_in(p[9]), .compare_low_in(p[10]),
        .oq_push_in(p[11]), .oq_data_in(od), .oq_pop_in(p[12]), .new_message_in(p[13]),
        .deadlock_in(p[18]), .device_clear_in(p[19]), .oq_data_out(oq), .oq_valid_out(ov),
        .eq_push_in(p[14]), .eq_number_in(en), .eq_msg_in(en[7:0]), .eq_pop_in(p[15]),
        .eq_number_out(eno), .eq_msg_out(emo), .eq_valid_out(ev),
        .event_summary_bit_out(s_evt), .message_available_bit_out(s_msg),
        .error_available_out(s_err), .source_summary_bit_out(s_src),
        .measure_summary_bit_out(s_meas));
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task w(input int n);
        repeat (n) @(negedge clock_in);
    endtask : w
    task pl(input int i);
        @(negedge clock_in);
        p[i] = 1'b1;
        @(negedge clock_in);
        p[i] = 1'b0;
    endtask : pl
    task rchk(input status_event_pkg::reg_sel_t s, input logic [7:0] e);
        ctl.issue(3'h4, s, 8'h00, junk);
        chk(32'(junk), {23'h0, 1'b1, e});
    endtask : rchk
    task t_std;
        pl(0); w(3); chk(32'(s_evt), 32'h0);
        ctl.issue(3'h2, status_event_pkg::SEL_STD_ENABLE, 8'h01, junk); w(3);
        chk(32'(s_evt), 32'h1);
        rchk(status_event_pkg::SEL_STD_ENABLE, 8'h01);
        rchk(status_event_pkg::SEL_STD_LATCH, 8'h01);
        rchk(status_event_pkg::SEL_STD_LATCH, 8'h00);
        p[1] = 1'b1; pl(0); w(2); rchk(status_event_pkg::SEL_STD_LATCH, 8'h00);
        p[1] = 1'b0; w(2); rchk(status_event_pkg::SEL_STD_LATCH, 8'h01);
    endtask : t_std
    task t_src;
        pl(2); pl(3); pl(4); pl(5); w(2);
        rchk(status_event_pkg::SEL_SRC_EVENT, 8'h87);
        rchk(status_event_pkg::SEL_MEAS_EVENT, 8'h80);
        p[7] = 1'b1; w(5); rchk(status_event_pkg::SEL_SRC_COND, 8'h20);
        p[7] = 1'b0; w(5); rchk(status_event_pkg::SEL_SRC_EVENT, 8'h20);
        pl(5); w(3); chk(32'(s_src), 32'h0);
        ctl.issue(3'h2, status_event_pkg::SEL_SRC_ENABLE, 8'h01, junk); w(3);
        chk(32'(s_src), 32'h1);
        ctl.issue(3'h1, status_event_pkg::SEL_STD_LATCH, 8'h00, junk); w(3);
        chk(32'(s_src), 32'h0);
        rchk(status_event_pkg::SEL_SRC_EVENT, 8'h00);
    endtask : t_src
    task t_meas;
        p[8] = 1'b1; pl(6); w(4);
        rchk(status_event_pkg::SEL_MEAS_COND, 8'h20);
        rchk(status_event_pkg::SEL_MEAS_COND, 8'h20);
        rchk(status_event_pkg::SEL_MEAS_EVENT, 8'h60);
        p[17:16] = 2'h3; p[10:9] = 2'h3; w(5);
        rchk(status_event_pkg::SEL_MEAS_EVENT, 8'h0f);
        ctl.issue(3'h2, status_event_pkg::SEL_MEAS_ENABLE, 8'h04, junk);
        p[17] = 1'b0; w(4); p[17] = 1'b1; w(6);
        chk(32'(s_meas), 32'h1);
    endtask : t_meas
    task t_oq;
        od = 8'h5a; pl(11); od = 8'ha5; pl(11); w(1);
        chk(32'(s_msg), 32'h1);
        ctl.issue(3'h1, status_event_pkg::SEL_STD_LATCH, 8'h00, junk);
        pl(12); chk(32'({ov, oq}), 32'h15a);
        pl(12); chk(32'({ov, oq}), 32'h1a5);
        w(1); chk(32'(s_msg), 32'h0);
        pl(11); pl(13); w(2); chk(32'(s_msg), 32'h0);
        pl(11); pl(18); w(2); chk(32'(s_msg), 32'h0);
        pl(11); pl(19); w(2); chk(32'(s_msg), 32'h0);
    endtask : t_oq
    task t_eq;
        for (int i = 1; i < 4; i++) begin
            en = 16'(i);
            pl(14);
        end
        w(2); chk(32'(s_err), 32'h1);
        pl(15); chk(32'({ev, eno, emo}), {7'h0, 1'b1, 16'h0001, 8'h01});
        pl(15); chk(32'({ev, eno, emo}), {7'h0, 1'b1, 16'hfea2, 8'h01});
        w(2); chk(32'(s_err), 32'h0);
        pl(14); ctl.issue(3'h1, status_event_pkg::SEL_STD_LATCH, 8'h00, junk); w(2);
        chk(32'(s_err), 32'h0);
    endtask : t_eq
    task tally_and_finish;
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        w(2); reset_in = 1'b0; w(1);
        t_std; t_src; t_meas; t_oq; t_eq;
        tally_and_finish;
    end
    initial begin
        #100000;
        miscompares++;
        tally_and_finish;
    end
endmodule : instrument_status_event_registers_tb_top
